// ===== dv/rbrp_asserts.sv
// Pin checks for the RAM back-end port.
// Assumes a bind onto rbrp_port and a static MODE_ASYNC.
`timescale 1ns/1ns
`default_nettype none
module rbrp_asserts (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic MODE_ASYNC,
  input wire logic BACKEND_STALL_N,
  input wire logic [15:0] RAM_READ_DATA,
  input wire logic [15:0] RD_DATA,
  input wire logic RD_VALID,
  input wire logic RAM_READ_STROBE_N,
  input wire logic RAM_WRITE_STROBE_N,
  input wire logic RAM_SELECT_N,
  input wire logic [1:0] ACCESS_TYPE_CODE,
  input wire logic [10:0] RAM_ADDR_OUT,
  input wire logic [15:0] RAM_WRITE_DATA
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // ****
  // Strobe framing
  // ****
  select_frame_a:
    assert property (!(RAM_READ_STROBE_N && RAM_WRITE_STROBE_N) |-> !RAM_SELECT_N)
    else $error("strobe without select");
  type_code_a:
    assert property (!RAM_SELECT_N |-> ACCESS_TYPE_CODE != 2'h3) else $error("bad type");
  sync_read_a:
    assert property (!MODE_ASYNC && $fell(RAM_READ_STROBE_N) |-> !RAM_SELECT_N ##1
      RAM_READ_STROBE_N && RAM_SELECT_N ##2 RD_VALID && RD_DATA == $past(RAM_READ_DATA, 2))
    else $error("sync read");
  sync_write_a:
    assert property (!MODE_ASYNC && $fell(RAM_WRITE_STROBE_N) |-> !RAM_SELECT_N ##1
      RAM_WRITE_STROBE_N && RAM_SELECT_N) else $error("sync write");
  // ****
  // Async setup, hold and stretch
  // ****
  read_setup_a:
    assert property (MODE_ASYNC && $fell(RAM_READ_STROBE_N) |-> !$past(RAM_SELECT_N) &&
      $stable(RAM_ADDR_OUT)) else $error("read setup");
  write_setup_a:
    assert property (MODE_ASYNC && $fell(RAM_WRITE_STROBE_N) |-> !$past(RAM_SELECT_N) &&
      $stable({RAM_ADDR_OUT, RAM_WRITE_DATA})) else $error("write setup");
  read_hold_a:
    assert property (MODE_ASYNC && $rose(RAM_READ_STROBE_N) |-> !RAM_SELECT_N &&
      $stable(RAM_ADDR_OUT) ##1 RAM_SELECT_N && RD_VALID &&
      RD_DATA == $past(RAM_READ_DATA, 2)) else $error("read hold");
  write_hold_a:
    assert property (MODE_ASYNC && $rose(RAM_WRITE_STROBE_N) |-> !RAM_SELECT_N &&
      $stable({RAM_ADDR_OUT, RAM_WRITE_DATA}) ##1 RAM_SELECT_N) else $error("write hold");
  stall_stretch_a:
    assert property (MODE_ASYNC && !BACKEND_STALL_N [*3] ##0 !(RAM_READ_STROBE_N &&
      RAM_WRITE_STROBE_N) |=> $stable({RAM_READ_STROBE_N, RAM_WRITE_STROBE_N}))
    else $error("stall ignored");
  cover property (MODE_ASYNC && $rose(RAM_READ_STROBE_N));
  cover property (!MODE_ASYNC && RD_VALID);
  cover property (!BACKEND_STALL_N && !RAM_WRITE_STROBE_N);
endmodule
`default_nettype wire

// ===== dv/rbrp_ram_model.sv
// Behavioural RAM with a stalling back end, far side of the port.
// Assumes one clock shared with the port.
`timescale 1ns/1ns
`default_nettype none
module rbrp_ram_model (
  input wire logic clk,
  input wire logic mode_async,
  input wire logic slow,
  input wire logic grant_en,
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [10:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  output logic stall_n = 1'b1,
  output logic grant_n = 1'b1
);
  logic [15:0] mem [0:2047];
  logic [15:0] q_r = 16'h0;
  logic [2:0] tick_r = 3'h0;
  // Store on strobe; idle bus flips so stale words never match
  always @(posedge clk) begin
    if (!sel_n && !wr_n) mem[addr] <= wdata;
    if (!sel_n && !rd_n && !mode_async) q_r <= mem[addr];
    else q_r <= ~q_r;
  end
  // Async parts drive data straight through while read strobe is low
  assign rdata = (mode_async && !sel_n && !rd_n) ? mem[addr] : q_r;
  // stall and grant driven off clock edge
  always @(posedge clk) begin
    tick_r <= tick_r + 3'h1;
    stall_n <= !(mode_async && slow && tick_r[2]);
    grant_n <= !grant_en;
  end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for rbrp_port against a behavioural RAM.
// Assumes the package, defines and both dv modules are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "rbrp_defines.svh"
module testbench;
  import rbrp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic mode = 1'b0;
  logic slow = 1'b0;
  logic grant_en = 1'b0;
  logic req_valid = 1'b0;
  rbrp_req_t req = '0;
  wire logic ready, rd_valid, sel_n, rd_n, wr_n, stall_n, grant_n;
  wire logic [15:0] rd_data, rdata, wdata;
  wire logic [1:0] kind;
  wire logic [10:0] addr;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [10:0] adr_tab [4] = '{11'h000, 11'h7ff, 11'h155, 11'h2aa};
  always #20 clk = ~clk;
  rbrp_port i_rbrp_port (.SYS_CLK(clk), .RESETN(rstn), .MODE_ASYNC(mode), .REQ(req),
    .REQ_VALID(req_valid), .REQ_READY(ready), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .RAM_GRANT_N(grant_n), .BACKEND_STALL_N(stall_n), .RAM_READ_DATA(rdata),
    .RAM_READ_STROBE_N(rd_n), .RAM_WRITE_STROBE_N(wr_n), .RAM_SELECT_N(sel_n),
    .ACCESS_TYPE_CODE(kind), .RAM_ADDR_OUT(addr), .RAM_WRITE_DATA(wdata));
  rbrp_ram_model i_rbrp_ram_model (.clk(clk), .mode_async(mode), .slow(slow),
    .grant_en(grant_en), .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .wdata(wdata), .rdata(rdata), .stall_n(stall_n), .grant_n(grant_n));
  // Hang guard, well above three passes
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // Request held until ready is seen at a falling edge, then through the next rising edge
  task automatic push(input logic w, input logic [1:0] k, input logic [10:0] a,
                      input logic [15:0] d);
    @(negedge clk);
    req = '{w, k, a, d};
    req_valid = 1'b1;
    while (ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic drop();
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  // Pattern differs per pass, so a lost write never reads back an older word
  function automatic logic [15:0] pat(input int i, input logic m, input logic s);
    return {5'h0, adr_tab[i]} ^ 16'hc35a ^ {8{s, m}};
  endfunction
  // Fill with grant withheld, refuse, then drain and read back
  task automatic fill_drain(input logic m, input logic s);
    int n;
    @(negedge clk);
    rstn = 1'b0;
    mode = m;
    slow = s;
    grant_en = 1'b0;
    repeat (4) @(negedge clk);
    check("idle_pins", {11'h0, sel_n, rd_n, wr_n, rd_valid, ready}, 16'h001d);
    rstn = 1'b1;
    for (int i = 0; i < 4; i++) push(1'b1, i[1:0], adr_tab[i], pat(i, m, s));
    drop();
    check("req_ready", {15'h0, ready}, 16'h0);
    grant_en = 1'b1;
    repeat (40) @(negedge clk);
    check("req_ready", {15'h0, ready}, 16'h1);
    for (int i = 0; i < 4; i++) begin
      push(1'b0, i[1:0], adr_tab[i], 16'h0);
      drop();
      n = 0;
      while (rd_valid !== 1'b1 && n < 40) begin
        @(negedge clk);
        n++;
      end
      check("rd_valid", {15'h0, rd_valid}, 16'h1);
      check("rd_data", rd_data, pat(i, m, s));
      check("type_code", {14'h0, kind}, {14'h0, (i == 3) ? `RBRP_KIND_DATA : i[1:0]});
      check("ram_addr", {5'h0, addr}, {5'h0, adr_tab[i]});
    end
  endtask
  initial begin
    fill_drain(1'b0, 1'b0);
    fill_drain(1'b1, 1'b0);
    fill_drain(1'b1, 1'b1);
    conclude();
  end
endmodule
bind rbrp_port rbrp_asserts i_rbrp_asserts (.SYS_CLK, .RESETN, .MODE_ASYNC,
  .BACKEND_STALL_N, .RAM_READ_DATA, .RD_DATA, .RD_VALID, .RAM_READ_STROBE_N,
  .RAM_WRITE_STROBE_N, .RAM_SELECT_N, .ACCESS_TYPE_CODE, .RAM_ADDR_OUT, .RAM_WRITE_DATA);
`default_nettype wire

// ===== rtl/rbrp_defines.svh
// Constants for the RAM back-end port: codes, widths, reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef RBRP_DEFINES_SVH
`define RBRP_DEFINES_SVH

// ****************************************
// Widths and FIFO depth
// ****************************************
`define RBRP_ADDR_W 11
`define RBRP_DATA_W 16
`define RBRP_KIND_W 2
`define RBRP_FIFO_DEPTH 4
`define RBRP_FIFO_PTR_W 2
`define RBRP_FIFO_CNT_W 3

// ****************************************
// Access type codes
// ****************************************
`define RBRP_KIND_DATA 2'h0
`define RBRP_KIND_STATUS 2'h1
`define RBRP_KIND_COMMAND 2'h2
`define RBRP_KIND_UNUSED 2'h3

// ****************************************
// Reset values and timing counts
// ****************************************
`define RBRP_ADDR_RST 11'h000
`define RBRP_DATA_RST 16'h0000
`define RBRP_STROBE_MIN_CYC 1

`endif

// ===== rtl/rbrp_pkg.sv
// Types shared by the RAM back-end port and its FIFO.
// Assumes rbrp_defines.svh is on the include path.
`include "rbrp_defines.svh"

package rbrp_pkg;

  // ****************************************
  // Request carried through the FIFO
  // ****************************************
  typedef struct packed {
    logic write;
    logic [`RBRP_KIND_W-1:0] kind;
    logic [`RBRP_ADDR_W-1:0] addr;
    logic [`RBRP_DATA_W-1:0] wdata;
  } rbrp_req_t;

  // ****************************************
  // Access sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    RBRP_IDLE,
    RBRP_A_SETUP,
    RBRP_A_STROBE,
    RBRP_A_HOLD,
    RBRP_S_ACCESS,
    RBRP_S_CAPTURE
  } rbrp_state_t;

endpackage

// ===== rtl/rbrp_port.sv
// RAM back-end port of a bus remote-terminal core, with its request FIFO.
// Assumes one 25 MHz clock SYS_CLK; RAM grant and stall cross in via two flip-flops.
//
// What this block does
// - Sync read strobe, data captured next edge
// - Async strobes low one cycle, stretched
// - Async read address one cycle around
// - Async read data taken at strobe rise
// - Async write address/data one cycle around
// - Chip select timed like address
// - Read, select outputs and stall input active low
// - Stall asserted lengthens current async strobe
// - Type code 00 data, 01 status, 10 command
// - Eleven-bit RAM address output
// - Sync write strobe commits on edge
// - Sixteen-bit write data output
`timescale 1ns/1ns
`default_nettype none
`include "rbrp_defines.svh"

// ****************************************
// Request FIFO
// ****************************************
module rbrp_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = `RBRP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [`RBRP_FIFO_PTR_W-1:0] wr_ptr_r;
  logic [`RBRP_FIFO_PTR_W-1:0] rd_ptr_r;
  logic [`RBRP_FIFO_CNT_W-1:0] count_r;
  logic [`RBRP_FIFO_CNT_W-1:0] count_nxt;
  logic space_r;
  logic push;
  logic pop;

  // Ready comes from a flop so the source sees no combinational path
  assign push = in_valid && space_r;
  assign pop = out_valid && out_ready;
  assign in_ready = space_r;
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];

  // Occupancy after this edge
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 3'h1;
    end else if (pop && !push) begin
      count_nxt = count_r - 3'h1;
    end
  end

  // Pointers, count and space flag
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      space_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 2'h1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 2'h1;
      end
      count_r <= count_nxt;
      space_r <= (count_nxt != DEPTH[`RBRP_FIFO_CNT_W-1:0]);
    end
  end

  // Storage, no reset needed on the data words
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule

// ****************************************
// RAM back-end port
// ****************************************
module rbrp_port (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic MODE_ASYNC,
  input wire rbrp_pkg::rbrp_req_t REQ,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  output logic [`RBRP_DATA_W-1:0] RD_DATA,
  output logic RD_VALID,
  input wire logic RAM_GRANT_N,
  input wire logic BACKEND_STALL_N,
  input wire logic [`RBRP_DATA_W-1:0] RAM_READ_DATA,
  output logic RAM_READ_STROBE_N,
  output logic RAM_WRITE_STROBE_N,
  output logic RAM_SELECT_N,
  output logic [`RBRP_KIND_W-1:0] ACCESS_TYPE_CODE,
  output logic [`RBRP_ADDR_W-1:0] RAM_ADDR_OUT,
  output logic [`RBRP_DATA_W-1:0] RAM_WRITE_DATA
);
  import rbrp_pkg::*;

  rbrp_req_t fifo_req;
  rbrp_req_t req_r;
  rbrp_req_t cur;
  rbrp_state_t state_r;
  rbrp_state_t state_nxt;
  logic fifo_valid;
  logic pop;
  logic [2:0] mode_sync_r;
  logic [1:0] grant_sync_r;
  logic [1:0] stall_sync_r;
  logic capture;
  logic [`RBRP_DATA_W-1:0] cap_r;
  logic cap_go_r;

  // Never emit the unused code; fold it onto a data transfer
  function automatic logic [`RBRP_KIND_W-1:0] clean_kind(input logic [`RBRP_KIND_W-1:0] k);
    clean_kind = (k == `RBRP_KIND_UNUSED) ? `RBRP_KIND_DATA : k;
  endfunction

  // Requests queue here until the RAM is granted
  rbrp_fifo #(
    .WIDTH($bits(rbrp_req_t)),
    .DEPTH(`RBRP_FIFO_DEPTH)
  ) u_fifo (
    .clk(SYS_CLK),
    .resetn(RESETN),
    .in_data(REQ),
    .in_valid(REQ_VALID),
    .in_ready(REQ_READY),
    .out_data(fifo_req),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // mode strap resampled
  // Mode is static; a change mid-access is not supported
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      mode_sync_r <= 3'h0;
    end else begin
      mode_sync_r <= {mode_sync_r[1:0], MODE_ASYNC};
    end
  end

  // grant and stall synchronised
  // Two flops add latency: stall stretches two cycles after it drops
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      grant_sync_r <= 2'h3;
      stall_sync_r <= 2'h3;
    end else begin
      grant_sync_r <= {grant_sync_r[0], RAM_GRANT_N};
      stall_sync_r <= {stall_sync_r[0], BACKEND_STALL_N};
    end
  end

  // ****************************************
  // Access sequencer
  // ****************************************
  assign pop = (state_r == RBRP_IDLE) && fifo_valid && !grant_sync_r[1];
  assign cur = (state_r == RBRP_IDLE) ? fifo_req : req_r;

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RBRP_IDLE: begin
        if (pop) begin
          state_nxt = mode_sync_r[2] ? RBRP_A_SETUP : RBRP_S_ACCESS;
        end
      end
      RBRP_A_SETUP: begin
        state_nxt = RBRP_A_STROBE;
      end
      RBRP_A_STROBE: begin
        if (stall_sync_r[1]) begin
          state_nxt = RBRP_A_HOLD;
        end
      end
      RBRP_A_HOLD: begin
        state_nxt = RBRP_IDLE;
      end
      RBRP_S_ACCESS: begin
        state_nxt = req_r.write ? RBRP_IDLE : RBRP_S_CAPTURE;
      end
      RBRP_S_CAPTURE: begin
        state_nxt = RBRP_IDLE;
      end
      default: begin
        state_nxt = RBRP_IDLE;
      end
    endcase
  end

  // State and latched request
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      state_r <= RBRP_IDLE;
      req_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (pop) begin
        req_r <= fifo_req;
      end
    end
  end

  // ****************************************
  // RAM pin drivers
  // ****************************************
  // address, select, data framed
  // Address and select stand through setup, strobe and hold
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      RAM_SELECT_N <= 1'b1;
      RAM_ADDR_OUT <= `RBRP_ADDR_RST;
      ACCESS_TYPE_CODE <= `RBRP_KIND_DATA;
      RAM_WRITE_DATA <= `RBRP_DATA_RST;
    end else begin
      case (state_nxt)
        RBRP_A_SETUP, RBRP_A_STROBE, RBRP_A_HOLD, RBRP_S_ACCESS: begin
          RAM_SELECT_N <= 1'b0;
          RAM_ADDR_OUT <= cur.addr;
          ACCESS_TYPE_CODE <= clean_kind(cur.kind);
          RAM_WRITE_DATA <= cur.wdata;
        end
        default: begin
          // Values kept to avoid needless pin toggling
          RAM_SELECT_N <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      RAM_READ_STROBE_N <= 1'b1;
      RAM_WRITE_STROBE_N <= 1'b1;
    end else begin
      case (state_nxt)
        RBRP_A_STROBE, RBRP_S_ACCESS: begin
          RAM_READ_STROBE_N <= cur.write;
          RAM_WRITE_STROBE_N <= !cur.write;
        end
        default: begin
          RAM_READ_STROBE_N <= 1'b1;
          RAM_WRITE_STROBE_N <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Read data return
  // ****************************************
  // async capture at strobe rise, sync one edge later
  assign capture = ((state_r == RBRP_A_STROBE) && (state_nxt == RBRP_A_HOLD) && !req_r.write)
                   || (state_r == RBRP_S_CAPTURE);

  // The capture flop is the first stage; the output flop the second
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      cap_r <= `RBRP_DATA_RST;
      cap_go_r <= 1'b0;
      RD_DATA <= `RBRP_DATA_RST;
      RD_VALID <= 1'b0;
    end else begin
      if (capture) begin
        cap_r <= RAM_READ_DATA;
      end
      cap_go_r <= capture;
      if (cap_go_r) begin
        RD_DATA <= cap_r;
      end
      RD_VALID <= cap_go_r;
    end
  end
endmodule

`default_nettype wire
